// ### hdl/dcr_top.sv
`timescale 1ns/10ps
// Summary of operation
// - Group 110 write loads channel clear value
// - Group 111 selects control registers by subfield
// - Control select decodes two of five register targets
// - Channel configuration written per addressed channel
// - Main control fields decoded, others ignored
// - Watchdog runs only when enabled, off at reset
// - Period code picks 5/10/100/200 ms
// - All-boost bit powers all four boosts
// - Channel configuration fields decoded, others ignored
// - Channel address ignored for global registers
// - Participating channels load clear value on clear
// - Output enable drives channel, off at reset
module dcr_top #(
    parameter int unsigned WD_CYC_0 = dcr_pkg::WD_CYC0,
    parameter int unsigned WD_CYC_1 = dcr_pkg::WD_CYC1,
    parameter int unsigned WD_CYC_2 = dcr_pkg::WD_CYC2,
    parameter int unsigned WD_CYC_3 = dcr_pkg::WD_CYC3
) (
    // Clock and reset
    input  wire logic                          sys_clk,
    input  wire logic                          rst,
    // Serial pins
    input  wire logic                          sclk,
    input  wire logic                          sync_n,
    input  wire logic                          sdin,
    // Device address straps and clear pin
    input  wire logic                          device_addr_hi,
    input  wire logic                          device_addr_lo,
    input  wire logic                          clear_in,
    // Register contents
    output dcr_pkg::dcr_main_ctrl_t            main_control,
    output dcr_pkg::dcr_chan_cfg_t [3:0]       channel_configuration,
    // Channel drive
    output logic                     [3:0]     output_drive,
    output logic                     [3:0]     boost_drive,
    // Clear load events
    output logic                               clear_load,
    output logic                     [1:0]     clear_chan,
    output logic                     [15:0]    clear_value,
    // Status
    output logic                               frame_accepted,
    output logic                               watchdog_alert
);
    typedef struct packed {
        logic                             sclk_s1;
        logic                             sclk_s2;
        logic                             sclk_s3;
        logic                             sync_n_s1;
        logic                             sync_n_s2;
        logic                             sync_n_s3;
        logic                             sdin_s1;
        logic                             sdin_s2;
        logic                             clr_s1;
        logic                             clr_s2;
        logic                             clr_s3;
        logic [1:0]                       dev_s1;
        logic [1:0]                       dev_s2;
        logic [23:0]                      shift;
        logic [4:0]                       bit_cnt;
        dcr_pkg::dcr_main_ctrl_t          main;
        dcr_pkg::dcr_chan_cfg_t [3:0]     cfg;
        logic [3:0]                       out_drive;
        logic [3:0]                       boost_drive;
        logic                             frame_acc;
        logic                             wd_alert;
        dcr_pkg::dcr_clr_state_t          clr_state;
        logic [2:0]                       clr_idx;
        logic                             clr_pend;
        logic [1:0]                       clr_pend_ch;
        logic                             clear_load;
        logic [1:0]                       clear_chan;
        logic [15:0]                      clear_value;
    } dcr_top_state_t;

    dcr_top_state_t               st_ff;
    dcr_top_state_t               nxt_st;
    logic                         sclk_fall;
    logic                         sync_rise;
    logic                         frame_ok;
    logic                         frame_foreign;
    logic                         clear_hit;
    logic                         ctrl_hit;
    logic                         main_hit;
    logic                         chan_hit;
    logic                         bad_sel;
    logic [1:0]                   hit_ch;
    logic                         clr_edge;
    logic                         pend_part;
    logic                         mem_we;
    logic [1:0]                   mem_waddr;
    logic [15:0]                  mem_wdata;
    logic                         mem_re;
    logic [1:0]                   mem_raddr;
    logic [15:0]                  mem_rdata;
    logic [dcr_pkg::WD_CNT_W-1:0] wd_limit;
    logic                         wd_timeout;

    function automatic logic [1:0] chan_of(input logic [23:0] f);
        chan_of = f[dcr_pkg::CH_MSB:dcr_pkg::CH_LSB];
    endfunction

    always_comb begin
        nxt_st = st_ff;
        // Pin synchronisers; data reads the second stage, edge detects also read the third
        nxt_st.sclk_s1   = sclk;
        nxt_st.sclk_s2   = st_ff.sclk_s1;
        nxt_st.sclk_s3   = st_ff.sclk_s2;
        nxt_st.sync_n_s1 = sync_n;
        nxt_st.sync_n_s2 = st_ff.sync_n_s1;
        nxt_st.sync_n_s3 = st_ff.sync_n_s2;
        nxt_st.sdin_s1   = sdin;
        nxt_st.sdin_s2   = st_ff.sdin_s1;
        nxt_st.clr_s1    = clear_in;
        nxt_st.clr_s2    = st_ff.clr_s1;
        nxt_st.clr_s3    = st_ff.clr_s2;
        nxt_st.dev_s1    = {device_addr_hi, device_addr_lo};
        nxt_st.dev_s2    = st_ff.dev_s1;
        sclk_fall = st_ff.sclk_s3 & ~st_ff.sclk_s2;
        sync_rise = ~st_ff.sync_n_s3 & st_ff.sync_n_s2;
        clr_edge  = st_ff.clr_s2 & ~st_ff.clr_s3;

        // Deserialiser, MSB first, sampled on falling serial clock
        if (st_ff.sync_n_s2) begin
            nxt_st.bit_cnt = 5'h00;
        end else if (sclk_fall) begin
            nxt_st.shift = {st_ff.shift[22:0], st_ff.sdin_s2};
            if (st_ff.bit_cnt != 5'(dcr_pkg::FRAME_BITS + 1)) begin
                nxt_st.bit_cnt = st_ff.bit_cnt + 5'h01;
            end
        end

        // Exact length write to own device address only
        frame_ok = sync_rise && st_ff.bit_cnt == 5'(dcr_pkg::FRAME_BITS)
                   && !st_ff.shift[dcr_pkg::RW_BIT]
                   && st_ff.shift[dcr_pkg::DEV_MSB:dcr_pkg::DEV_LSB] == st_ff.dev_s2;
        frame_foreign = sync_rise
                   && st_ff.shift[dcr_pkg::DEV_MSB:dcr_pkg::DEV_LSB] != st_ff.dev_s2;
        hit_ch    = chan_of(st_ff.shift);
        clear_hit = frame_ok && st_ff.shift[dcr_pkg::GRP_MSB:dcr_pkg::GRP_LSB]
                    == dcr_pkg::GRP_CLEAR;
        // Control group only on select 111
        ctrl_hit  = frame_ok && st_ff.shift[dcr_pkg::GRP_MSB:dcr_pkg::GRP_LSB]
                    == dcr_pkg::GRP_CTRL;
        // Control select decode; slew, dc-to-dc, software held elsewhere
        main_hit  = ctrl_hit && st_ff.shift[dcr_pkg::CSEL_MSB:dcr_pkg::CSEL_LSB]
                    == dcr_pkg::CSEL_MAIN && !st_ff.shift[dcr_pkg::MC_ZERO_BIT];
        chan_hit  = ctrl_hit && st_ff.shift[dcr_pkg::CSEL_MSB:dcr_pkg::CSEL_LSB]
                    == dcr_pkg::CSEL_CHAN;
        // Codes above software register are dropped
        bad_sel   = ctrl_hit && st_ff.shift[dcr_pkg::CSEL_MSB:dcr_pkg::CSEL_LSB]
                    > dcr_pkg::CSEL_SOFT;
        nxt_st.frame_acc = frame_ok;

        mem_we    = clear_hit;
        mem_waddr = hit_ch;
        mem_wdata = st_ff.shift[dcr_pkg::DATA_MSB:0];

        if (main_hit) begin
            nxt_st.main.status_echo_enable = st_ff.shift[dcr_pkg::MC_ECHO_BIT];
            nxt_st.main.watchdog_enable    = st_ff.shift[dcr_pkg::MC_WDEN_BIT];
            nxt_st.main.watchdog_period    =
                st_ff.shift[dcr_pkg::MC_WDPER_MSB:dcr_pkg::MC_WDPER_LSB];
            nxt_st.main.all_outputs_on     = st_ff.shift[dcr_pkg::MC_ALLOUT_BIT];
            nxt_st.main.all_boost_on       = st_ff.shift[dcr_pkg::MC_ALLBST_BIT];
        end

        if (chan_hit) begin
            nxt_st.cfg[hit_ch].amp_power             = st_ff.shift[dcr_pkg::CC_AMP_BIT];
            nxt_st.cfg[hit_ch].clear_participate     = st_ff.shift[dcr_pkg::CC_CLRP_BIT];
            nxt_st.cfg[hit_ch].output_on             = st_ff.shift[dcr_pkg::CC_OUT_BIT];
            nxt_st.cfg[hit_ch].sense_resistor_select = st_ff.shift[dcr_pkg::CC_RSEL_BIT];
            nxt_st.cfg[hit_ch].boost_power           = st_ff.shift[dcr_pkg::CC_BOOST_BIT];
            nxt_st.cfg[hit_ch].range_select          =
                st_ff.shift[dcr_pkg::CC_RANGE_MSB:dcr_pkg::CC_RANGE_LSB];
        end

        // Output drive; OR of both methods, host keeps to one
        for (int i = 0; i < 4; i++) begin
            nxt_st.out_drive[i]   = st_ff.cfg[i].output_on | st_ff.main.all_outputs_on;
            nxt_st.boost_drive[i] = st_ff.cfg[i].boost_power | st_ff.main.all_boost_on;
        end

        // Watchdog alert; a timeout in a kick cycle still sets
        if (wd_timeout) begin
            nxt_st.wd_alert = 1'b1;
        end else if (frame_ok) begin
            nxt_st.wd_alert = 1'b0;
        end

        // Clear walk over four channels; edges mid-walk are ignored
        mem_re    = 1'b0;
        mem_raddr = st_ff.clr_idx[1:0];
        case (st_ff.clr_state)
            dcr_pkg::CLR_IDLE: begin
                if (clr_edge) begin
                    nxt_st.clr_state = dcr_pkg::CLR_RUN;
                    nxt_st.clr_idx   = 3'h0;
                end
            end
            dcr_pkg::CLR_RUN: begin
                if (st_ff.clr_idx != 3'h4) begin
                    mem_re         = 1'b1;
                    nxt_st.clr_idx = st_ff.clr_idx + 3'h1;
                end else begin
                    nxt_st.clr_state = dcr_pkg::CLR_IDLE;
                end
            end
            default: begin
                nxt_st.clr_state = dcr_pkg::CLR_IDLE;
            end
        endcase
        nxt_st.clr_pend    = mem_re;
        nxt_st.clr_pend_ch = mem_raddr;
        pend_part          = st_ff.clr_pend && st_ff.cfg[st_ff.clr_pend_ch].clear_participate;
        nxt_st.clear_load  = pend_part;
        if (st_ff.clr_pend) begin
            nxt_st.clear_chan  = st_ff.clr_pend_ch;
            nxt_st.clear_value = mem_rdata;
        end

        case (st_ff.main.watchdog_period)
            2'h0:    wd_limit = dcr_pkg::WD_CNT_W'(WD_CYC_0);
            2'h1:    wd_limit = dcr_pkg::WD_CNT_W'(WD_CYC_1);
            2'h2:    wd_limit = dcr_pkg::WD_CNT_W'(WD_CYC_2);
            default: wd_limit = dcr_pkg::WD_CNT_W'(WD_CYC_3);
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_ff           <= '0;
            st_ff.sync_n_s1 <= 1'b1;
            st_ff.sync_n_s2 <= 1'b1;
            st_ff.sync_n_s3 <= 1'b1;
            st_ff.main      <= dcr_pkg::MAIN_CTRL_RST;
            st_ff.cfg       <= {4{dcr_pkg::CHAN_CFG_RST}};
            st_ff.clr_state <= dcr_pkg::CLR_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    dcr_clear_mem u_clear_mem (
        .sys_clk (sys_clk),
        .rst     (rst),
        .we      (mem_we),
        .waddr   (mem_waddr),
        .wdata   (mem_wdata),
        .re      (mem_re),
        .raddr   (mem_raddr),
        .rdata   (mem_rdata)
    );

    dcr_watchdog u_watchdog (
        .sys_clk (sys_clk),
        .rst     (rst),
        .enable  (st_ff.main.watchdog_enable),
        .kick    (frame_ok),
        .limit   (wd_limit),
        .timeout (wd_timeout)
    );

    assign main_control          = st_ff.main;
    assign channel_configuration = st_ff.cfg;
    assign output_drive          = st_ff.out_drive;
    assign boost_drive           = st_ff.boost_drive;
    assign clear_load            = st_ff.clear_load;
    assign clear_chan            = st_ff.clear_chan;
    assign clear_value           = st_ff.clear_value;
    assign frame_accepted        = st_ff.frame_acc;
    assign watchdog_alert        = st_ff.wd_alert;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_clr_go;
        clr_edge && st_ff.clr_state == dcr_pkg::CLR_IDLE;
    endsequence

    sequence s_clr_walk;
        (st_ff.clr_state == dcr_pkg::CLR_RUN)[*5] ##1 (st_ff.clr_state == dcr_pkg::CLR_IDLE);
    endsequence

    a_clear_write: assert property (clear_hit |-> mem_we && mem_waddr == hit_ch)
        else $error("Clear value write missed");

    a_group_gate: assert property (!ctrl_hit |=> $stable(st_ff.main))
        else $error("Main control changed outside control group");

    a_main_decode: assert property (main_hit |=>
        st_ff.main.watchdog_enable == $past(st_ff.shift[10])
        && st_ff.main.all_boost_on == $past(st_ff.shift[4]))
        else $error("Main control decoded wrongly");

    a_chan_decode: assert property (chan_hit |=>
        st_ff.cfg[$past(hit_ch)].output_on == $past(st_ff.shift[6])
        && st_ff.cfg[$past(hit_ch)].range_select == $past(st_ff.shift[2:0]))
        else $error("Channel configuration decoded wrongly");

    for (genvar g = 0; g < 4; g++) begin : g_chan_chk
        a_chan_keep: assert property (!(chan_hit && hit_ch == g) |=>
            $stable(st_ff.cfg[g]))
            else $error("Channel configuration changed for another channel");
        a_out_drive: assert property (##1 !st_ff.cfg[g].output_on
            && !st_ff.main.all_outputs_on ##1 1'b1 |-> !output_drive[g])
            else $error("Output driven while disabled");
    end

    a_boost_all: assert property (st_ff.main.all_boost_on |=> boost_drive == 4'hf)
        else $error("All-boost did not power every channel");

    a_bad_select: assert property (bad_sel |=> $stable(st_ff.main) && $stable(st_ff.cfg))
        else $error("Undefined control select changed state");

    a_addr_filter: assert property (frame_foreign |-> !mem_we ##1
        ($stable(st_ff.main) && $stable(st_ff.cfg) && !frame_accepted))
        else $error("Foreign frame updated a register");

    a_clear_walk: assert property (s_clr_go |=> s_clr_walk)
        else $error("Clear walk wrong length");

    a_clear_gate: assert property (clear_load |-> $past(pend_part))
        else $error("Clear load for non-participating channel");
endmodule

// ### include/dcr_pkg.sv
package dcr_pkg;

    // Frame layout
    localparam int FRAME_BITS    = 24;
    localparam int RW_BIT        = 23;
    localparam int DEV_MSB       = 22;
    localparam int DEV_LSB       = 21;
    localparam int GRP_MSB       = 20;
    localparam int GRP_LSB       = 18;
    localparam int CH_MSB        = 17;
    localparam int CH_LSB        = 16;
    localparam int CSEL_MSB      = 15;
    localparam int CSEL_LSB      = 13;
    localparam int DATA_MSB      = 15;

    // Register group and control select codes
    localparam logic [2:0] GRP_CLEAR      = 3'h6;
    localparam logic [2:0] GRP_CTRL       = 3'h7;
    localparam logic [2:0] CSEL_SLEW      = 3'h0;
    localparam logic [2:0] CSEL_MAIN      = 3'h1;
    localparam logic [2:0] CSEL_CHAN      = 3'h2;
    localparam logic [2:0] CSEL_BOOSTCTL  = 3'h3;
    localparam logic [2:0] CSEL_SOFT      = 3'h4;

    // Main control field positions
    localparam int MC_ZERO_BIT   = 12;
    localparam int MC_ECHO_BIT   = 11;
    localparam int MC_WDEN_BIT   = 10;
    localparam int MC_WDPER_MSB  = 9;
    localparam int MC_WDPER_LSB  = 8;
    localparam int MC_ALLOUT_BIT = 5;
    localparam int MC_ALLBST_BIT = 4;

    // Channel configuration field positions
    localparam int CC_AMP_BIT    = 8;
    localparam int CC_CLRP_BIT   = 7;
    localparam int CC_OUT_BIT    = 6;
    localparam int CC_RSEL_BIT   = 5;
    localparam int CC_BOOST_BIT  = 4;
    localparam int CC_RANGE_MSB  = 2;
    localparam int CC_RANGE_LSB  = 0;

    // Watchdog timing
    localparam int CLK_KHZ       = 100_000;
    localparam int WD_T0_MS      = 5;
    localparam int WD_T1_MS      = 10;
    localparam int WD_T2_MS      = 100;
    localparam int WD_T3_MS      = 200;
    localparam int WD_CYC0       = WD_T0_MS * CLK_KHZ;
    localparam int WD_CYC1       = WD_T1_MS * CLK_KHZ;
    localparam int WD_CYC2       = WD_T2_MS * CLK_KHZ;
    localparam int WD_CYC3       = WD_T3_MS * CLK_KHZ;
    localparam int WD_CNT_W      = 25;

    typedef struct packed {
        logic       amp_power;
        logic       clear_participate;
        logic       output_on;
        logic       sense_resistor_select;
        logic       boost_power;
        logic [2:0] range_select;
    } dcr_chan_cfg_t;

    typedef struct packed {
        logic       status_echo_enable;
        logic       watchdog_enable;
        logic [1:0] watchdog_period;
        logic       all_outputs_on;
        logic       all_boost_on;
    } dcr_main_ctrl_t;

    // Reset values
    localparam dcr_chan_cfg_t  CHAN_CFG_RST   = 8'h00;
    localparam dcr_main_ctrl_t MAIN_CTRL_RST  = 6'h00;
    localparam logic [15:0]    CLEAR_CODE_RST = 16'h0000;

    typedef enum logic {
        CLR_IDLE,
        CLR_RUN
    } dcr_clr_state_t;

    typedef struct packed {
        logic [WD_CNT_W-1:0] cnt;
        logic                timeout;
    } dcr_wd_state_t;

    typedef struct packed {
        logic [3:0][15:0] word;
        logic [15:0]      rdata;
    } dcr_mem_state_t;

endpackage

// ### hdl/dcr_clear_mem.sv
`timescale 1ns/10ps
module dcr_clear_mem (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // Write port
    input  wire logic        we,
    input  wire logic [1:0]  waddr,
    input  wire logic [15:0] wdata,
    // Read port, data one cycle after re
    input  wire logic        re,
    input  wire logic [1:0]  raddr,
    output logic      [15:0] rdata
);
    dcr_pkg::dcr_mem_state_t st_ff;
    dcr_pkg::dcr_mem_state_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        // Read before write: same-address collision returns the old word
        if (re) begin
            nxt_st.rdata = st_ff.word[raddr];
        end
        if (we) begin
            nxt_st.word[waddr] = wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_ff <= {{4{dcr_pkg::CLEAR_CODE_RST}}, 16'h0000};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rdata = st_ff.rdata;

    a_mem_store: assert property (@(posedge sys_clk) disable iff (rst)
        we && !(re && raddr == waddr) ##1 re && raddr == $past(waddr) && !we
        |=> rdata == $past(wdata, 2))
        else $error("Clear value not stored");
endmodule

// ### hdl/dcr_watchdog.sv
`timescale 1ns/10ps
module dcr_watchdog (
    // Clock and reset
    input  wire logic                         sys_clk,
    input  wire logic                         rst,
    // Control
    input  wire logic                         enable,
    input  wire logic                         kick,
    input  wire logic [dcr_pkg::WD_CNT_W-1:0] limit,
    // Event
    output logic                              timeout
);
    dcr_pkg::dcr_wd_state_t st_ff;
    dcr_pkg::dcr_wd_state_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.timeout = 1'b0;
        if (!enable || kick) begin
            nxt_st.cnt = '0;
        // Timeout at selected period; >= covers a shortened period
        end else if (st_ff.cnt >= limit - 25'h1) begin
            nxt_st.cnt = '0;
            nxt_st.timeout = 1'b1;
        end else begin
            nxt_st.cnt = st_ff.cnt + 25'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign timeout = st_ff.timeout;

    a_wd_disabled: assert property (@(posedge sys_clk) disable iff (rst)
        !enable |=> st_ff.cnt == '0 && !timeout)
        else $error("Watchdog ran while disabled");

    a_wd_period: assert property (@(posedge sys_clk) disable iff (rst)
        timeout |-> $past(st_ff.cnt) >= $past(limit) - 25'h1 && $past(enable))
        else $error("Watchdog fired before its period");
endmodule

// ### sim/dcr_host.sv
`timescale 1ns/10ps
// Serial host: sclk idles low, bits are taken on its falling edge
module dcr_host (
    // Clock
    input  wire logic sys_clk,
    // Serial pins
    output logic      sclk,
    output logic      sync_n,
    output logic      sdin
);
    initial begin
        sclk = 1'b0;
        sync_n = 1'b1;
        sdin = 1'b0;
    end
    task automatic send(input logic [23:0] f, input int n);
        @(negedge sys_clk) sync_n <= 1'b0;
        repeat (3) @(negedge sys_clk);
        for (int i = 23; i > 23 - n; i--) begin
            sdin <= f[i];
            sclk <= 1'b1;
            repeat (3) @(negedge sys_clk);
            sclk <= 1'b0;
            repeat (3) @(negedge sys_clk);
        end
        sync_n <= 1'b1;
        // Released line must not show the last bit
        sdin <= ~sdin;
        // Short tail so the caller still catches the accept pulse
        @(negedge sys_clk);
    endtask
endmodule

// ### sim/dcr_top_tb_top.sv
`timescale 1ns/10ps
module dcr_top_tb_top;
    logic                          sys_clk;
    logic                          rst;
    logic                          clear_in;
    logic                          sclk;
    logic                          sync_n;
    logic                          sdin;
    logic [1:0]                    own;
    dcr_pkg::dcr_main_ctrl_t       main_control;
    dcr_pkg::dcr_chan_cfg_t [3:0]  channel_configuration;
    logic [3:0]                    output_drive;
    logic [3:0]                    boost_drive;
    logic                          clear_load;
    logic [1:0]                    clear_chan;
    logic [15:0]                   clear_value;
    logic                          frame_accepted;
    logic                          watchdog_alert;
    logic [23:0]                   f;
    logic [5:0]                    m_main;
    logic [7:0]                    m_cfg [4];
    int                            m_clr [4];
    int                            lim [4] = '{20, 40, 60, 80};
    int                            err_total;
    int                            compares;
    int                            n;
    int                            p;

    // Short watchdog limits keep the run brief
    dcr_top #(.WD_CYC_0(20), .WD_CYC_1(40), .WD_CYC_2(60), .WD_CYC_3(80)) u_dcr_top (
        .sys_clk(sys_clk), .rst(rst), .sclk(sclk), .sync_n(sync_n), .sdin(sdin),
        .device_addr_hi(own[1]), .device_addr_lo(own[0]), .clear_in(clear_in),
        .main_control(main_control), .channel_configuration(channel_configuration),
        .output_drive(output_drive), .boost_drive(boost_drive), .clear_load(clear_load),
        .clear_chan(clear_chan), .clear_value(clear_value),
        .frame_accepted(frame_accepted), .watchdog_alert(watchdog_alert));
    dcr_host u_dcr_host (.sys_clk(sys_clk), .sclk(sclk), .sync_n(sync_n), .sdin(sdin));

    initial sys_clk = 1'b0;
    always #5 sys_clk = ~sys_clk;

    task automatic give_verdict();
        $display("Mismatches %0d, comparisons %0d", err_total, compares);
        if (err_total == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [45:0] g, input logic [45:0] e);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    function automatic logic [45:0] expv();
        logic [31:0] c;
        logic [3:0]  o;
        logic [3:0]  b;
        for (int i = 0; i < 4; i++) begin
            c[i*8+:8] = m_cfg[i];
            o[i] = m_cfg[i][5] | m_main[1];
            b[i] = m_cfg[i][3] | m_main[0];
        end
        return {m_main, c, o, b};
    endfunction

    function automatic logic [23:0] fr(logic [1:0] ch, logic [15:0] d);
        return {1'b0, own, 3'h7, ch, d};
    endfunction

    task automatic wr(input logic [23:0] fw, input int nb);
        logic acc;
        logic seen;
        acc = (nb == 24) && !fw[23] && (fw[22:21] == own);
        u_dcr_host.send(fw, nb);
        seen = 1'b0;
        for (int k = 0; k < 30 && !seen; k++) @(negedge sys_clk) seen = (frame_accepted === 1'b1);
        chk({45'h0, seen}, {45'h0, acc});
        if (acc && !seen) give_verdict();
        if (acc && fw[20:18] == 3'h6) m_clr[fw[17:16]] = fw[15:0];
        if (acc && fw[20:18] == 3'h7 && fw[15:13] == 3'h1 && !fw[12]) m_main = {fw[11:8], fw[5:4]};
        if (acc && fw[20:18] == 3'h7 && fw[15:13] == 3'h2) m_cfg[fw[17:16]] = {fw[8:4], fw[2:0]};
        @(negedge sys_clk);
        chk({main_control, channel_configuration, output_drive, boost_drive}, expv());
    endtask

    initial begin
        rst = 1'b1;
        clear_in = 1'b0;
        own = 2'h2;
        err_total = 0;
        compares = 0;
        m_main = 6'h00;
        for (int i = 0; i < 4; i++) begin
            m_cfg[i] = 8'h00;
            m_clr[i] = 0;
        end
        void'($urandom(39));
        repeat (3) @(negedge sys_clk);
        rst = 1'b0;
        @(negedge sys_clk);
        chk({main_control, channel_configuration, output_drive, boost_drive}, expv());
        repeat (40) begin
            f = 24'($urandom);
            if ($urandom % 4 != 0) f[22:21] = own;
            if ($urandom % 8 != 0) f[23] = 1'b0;
            if ($urandom % 4 != 0) f[20:19] = 2'h3;
            // Global enables stay off while per-channel ones are in use
            f[5:4] = (f[15:13] == 3'h1) ? 2'h0 : f[5:4];
            wr(f, 24);
        end
        wr(fr(2'h1, 16'h4170), 23);
        for (int i = 0; i < 4; i++) wr(fr(2'(i), 16'h4000 | (16'($urandom) & 16'h0187)), 24);
        wr(fr(2'h0, 16'h2030), 24);
        wr(fr(2'h0, 16'h2010), 24);
        wr(fr(2'h0, 16'h2000), 24);
        clear_in = 1'b1;
        n = 0;
        repeat (20) @(negedge sys_clk) if (clear_load === 1'b1) begin
            n++;
            chk({30'h0, clear_value}, {30'h0, 16'(m_clr[clear_chan])});
            chk({45'h0, m_cfg[clear_chan][6]}, 46'h1);
        end
        p = 0;
        for (int i = 0; i < 4; i++) p += m_cfg[i][6];
        chk(46'(n), 46'(p));
        clear_in = 1'b0;
        for (int i = 0; i < 4; i++) begin
            wr(fr(2'h3, 16'h2400 | (16'(i) << 8)), 24);
            repeat (lim[i] - 8) @(negedge sys_clk);
            chk({45'h0, watchdog_alert}, 46'h0);
            repeat (16) @(negedge sys_clk);
            chk({45'h0, watchdog_alert}, 46'h1);
        end
        wr(fr(2'h0, 16'h2000), 24);
        repeat (100) @(negedge sys_clk);
        chk({45'h0, watchdog_alert}, 46'h0);
        give_verdict();
    end
endmodule
